// file: design/bdp_pkg.sv
package bdp_pkg;

  // ----------------------------------------
  // widths and id bus layout
  // ----------------------------------------
  localparam int ID_W = 8;              // width of the completion id bus
  localparam int DBG_W = 7;             // width of the coherency debug id
  localparam int CNT_W = 3;             // width of the pending data count
  localparam int CNT_LSB = 5;           // count sits on id bits 7:5
  localparam int DBG_A_BIT = 7;         // first-phase bit carrying debug bit 6
  localparam int DBG_HI_LSB = 3;        // debug bits 5:3 go to second-phase 7:5
  localparam int SNP_HIT_BIT = 3;       // second-phase bit: shared hit seen
  localparam int SNP_SNOOP_MODIFIED_HIT_BIT = 4;      // second-phase bit: modified hit seen
  localparam int SYNC_W = 2;            // pins passing the synchroniser

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [ID_W-1:0] ID_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  // where the data of a deferred transaction comes from
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_MEMORY,
    SRC_REMOTE
  } bdp_src_e;

  // one deferred transaction waiting for its completion
  typedef struct packed {
    logic [ID_W-1:0] txn_id;            // id captured in the request phase
    bdp_src_e src;                      // data source
    logic has_data;                     // data will be returned
    logic data_line_read;               // plain line read
    logic ownership_line_read;          // line read for ownership
    logic shared_hit;                   // shared hit in the original snoop
    logic remote_snooped;               // line snooped on the other bus
    logic remote_snoop_modified_hit;                  // modified hit seen on the other bus
    logic buried_snoop_modified_hit;                  // buried modified hit
    logic inval_conflict;               // ownership-invalidate conflict
    logic [DBG_W-1:0] coherency_debug_id;
  } bdp_req_s;

endpackage

// file: design/bdp_sync.sv
// ----------------------------------------
// two-stage synchroniser, one per pin
// ----------------------------------------
module bdp_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [bdp_pkg::SYNC_W-1:0] pin_in,
  output logic [bdp_pkg::SYNC_W-1:0] pin_sync
);

  genvar gi;
  generate
    for (gi = 0; gi < bdp_pkg::SYNC_W; gi++)
    begin : g_bit
      logic meta_ff;                    // first stage, read only by second
      logic sync_ff;                    // second stage, safe to use
      // both stages only register
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= pin_in[gi];
          sync_ff <= meta_ff;
        end
      end
      assign pin_sync[gi] = sync_ff;
    end
  endgenerate

endmodule

// file: design/bdp_defer_phase.sv
// Overview of operation
// - strobe marks completion; id bus valid
// - strobe hands snoop ownership back
// - no-data transaction completes at strobe
// - data strobe with or after completion
// - completion strobe at most every two clocks
// - phase one id, phase two snoop results
// - shared hit on plain line reads if shared
// - count enable drives pending count bits
// - debug enable maps debug id bits
// - never modified hit for ownership reads
// - strobe order fixes data order
// - after reset both strobes coincide
// - early mode lets completion precede data
// - remote modified data waits remote ready
// - memory data completes once header arrives
// - buried hit or conflict gives retry
module bdp_defer_phase (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire bdp_pkg::bdp_req_s req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic early_defer_enable,
  input wire logic count_drive_enable,
  input wire logic debug_drive_enable,
  input wire logic mem_header,
  input wire logic data_ready,
  input wire logic remote_target_ready_pin,
  input wire logic deferral_mark_pin,
  output logic defer_completion_strobe,
  output logic [bdp_pkg::ID_W-1:0] defer_id_bus,
  output logic defer_id_second,
  output logic data_return_strobe,
  output logic defer_shared_hit,
  output logic defer_modified_hit,
  output logic retry_reply,
  output logic snoop_hold
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [bdp_pkg::SYNC_W-1:0] pins_sync; // {deferral mark, remote ready}
  bdp_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in({deferral_mark_pin, remote_target_ready_pin}),
    .pin_sync(pins_sync)
  );
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GATE,
    ST_PHASE_A,
    ST_PHASE_B,
    ST_DATA_WAIT
  } bdp_state_e;
  bdp_state_e state_ff, nxt_state;
  bdp_pkg::bdp_req_s cur_ff, nxt_cur;   // transaction being completed
  logic early_ff, nxt_early;            // mode latched per transaction
  logic hdr_ff, nxt_hdr;                // memory read header seen
  logic target_ready_ff, nxt_target_ready;              // remote target ready seen
  logic [bdp_pkg::CNT_W-1:0] cnt_ff, nxt_cnt; // marks minus data strobes
  logic ready_ff, nxt_ready;
  logic ids_ff, nxt_ids;
  logic [bdp_pkg::ID_W-1:0] id_ff, nxt_id;
  logic sec_ff, nxt_sec;
  logic ood_ff, nxt_ood;
  logic defer_shared_hit_ff, nxt_defer_shared_hit;
  logic defer_modified_hit_ff, nxt_defer_modified_hit;
  logic retry_ff, nxt_retry;
  logic hold_ff, nxt_hold;
  logic take;                           // request accepted this cycle
  logic gate_ok;                        // data source has cleared
  logic is_retry;                       // completion carries retry
  logic want_data;                      // data follows this completion
  logic [bdp_pkg::ID_W-1:0] id_a;       // first-phase id value
  logic [bdp_pkg::ID_W-1:0] id_b;       // second-phase id value
  assign take = req_valid && ready_ff;
  assign is_retry = cur_ff.buried_snoop_modified_hit || cur_ff.inval_conflict;
  assign want_data = cur_ff.has_data && !is_retry;
  // ----------------------------------------
  // id phase contents
  // ----------------------------------------
  // debug mapping wins over count, so the two never mix on the pins
  always_comb
  begin
    id_a = cur_ff.txn_id;
    id_b = '0;
    id_b[bdp_pkg::SNP_HIT_BIT] = cur_ff.shared_hit || cur_ff.remote_snooped;
    id_b[bdp_pkg::SNP_SNOOP_MODIFIED_HIT_BIT] = cur_ff.remote_snoop_modified_hit && !cur_ff.ownership_line_read;
    if (debug_drive_enable)
    begin
      id_a[bdp_pkg::DBG_A_BIT] = cur_ff.coherency_debug_id[6];
      id_b[7:5] = cur_ff.coherency_debug_id[5:3];
      id_b[2:0] = cur_ff.coherency_debug_id[2:0];
    end
    else if (count_drive_enable)
    begin
      // cnt_ff is the value in the strobe cycle, before that cycle's data strobe counts
      id_b[7:5] = cnt_ff;
    end
  end
  // ----------------------------------------
  // gating by data source
  // ----------------------------------------
  always_comb
  begin
    case (cur_ff.src)
      bdp_pkg::SRC_MEMORY: gate_ok = hdr_ff;
      bdp_pkg::SRC_REMOTE: gate_ok = target_ready_ff;
      default: gate_ok = 1'b1;
    endcase
  end
  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_early = early_ff;
    nxt_ready = ready_ff;
    nxt_ids = 1'b0;
    nxt_id = bdp_pkg::ID_RST;
    nxt_sec = 1'b0;
    nxt_ood = 1'b0;
    nxt_defer_shared_hit = 1'b0;
    nxt_defer_modified_hit = 1'b0;
    nxt_retry = 1'b0;
    nxt_hold = hold_ff;
    // sticky gates: a fresh event wins over the clear on a new take
    nxt_hdr = (hdr_ff && !take) || mem_header;
    nxt_target_ready = (target_ready_ff && !take) || pins_sync[0];
    // data strobes issued lower the pending count
    nxt_cnt = cnt_ff + {{(bdp_pkg::CNT_W-1){1'b0}}, pins_sync[1]}
      - {{(bdp_pkg::CNT_W-1){1'b0}}, ood_ff};
    case (state_ff)
      ST_IDLE:
      begin
        nxt_ready = !take;
        if (take)
        begin
          nxt_cur = req;
          nxt_early = early_defer_enable;
          nxt_hold = 1'b1;
          nxt_state = ST_GATE;
        end
      end
      ST_GATE:
      begin
        // coincident mode also waits until data can go with the strobe
        if ((is_retry || gate_ok) && (early_ff || !want_data || data_ready))
        begin
          nxt_ids = 1'b1;
          nxt_id = id_a;
          nxt_ood = want_data && !early_ff;
          nxt_defer_shared_hit = cur_ff.data_line_read && (cur_ff.shared_hit || cur_ff.remote_snooped);
          nxt_defer_modified_hit = cur_ff.remote_snoop_modified_hit && !cur_ff.ownership_line_read;
          nxt_retry = is_retry;
          nxt_hold = 1'b0;
          nxt_state = ST_PHASE_A;
        end
      end
      ST_PHASE_A:
      begin
        // strobe drops here, so it cannot come back for two clocks
        nxt_id = id_b;
        nxt_sec = 1'b1;
        nxt_state = ST_PHASE_B;
      end
      ST_PHASE_B:
      begin
        if (early_ff && want_data)
        begin
          nxt_state = ST_DATA_WAIT;
        end
        else
        begin
          // no data or data already gone: transaction is finished
          nxt_ready = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_DATA_WAIT:
      begin
        // one engine keeps data in completion order
        if (data_ready)
        begin
          nxt_ood = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_ready = 1'b1;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      early_ff <= 1'b0;
      hdr_ff <= 1'b0;
      target_ready_ff <= 1'b0;
      cnt_ff <= bdp_pkg::CNT_RST;
      ready_ff <= 1'b0;
      ids_ff <= 1'b0;
      id_ff <= bdp_pkg::ID_RST;
      sec_ff <= 1'b0;
      ood_ff <= 1'b0;
      defer_shared_hit_ff <= 1'b0;
      defer_modified_hit_ff <= 1'b0;
      retry_ff <= 1'b0;
      hold_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      early_ff <= nxt_early;
      hdr_ff <= nxt_hdr;
      target_ready_ff <= nxt_target_ready;
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_ready;
      ids_ff <= nxt_ids;
      id_ff <= nxt_id;
      sec_ff <= nxt_sec;
      ood_ff <= nxt_ood;
      defer_shared_hit_ff <= nxt_defer_shared_hit;
      defer_modified_hit_ff <= nxt_defer_modified_hit;
      retry_ff <= nxt_retry;
      hold_ff <= nxt_hold;
    end
  end
  assign req_ready = ready_ff;
  assign defer_completion_strobe = ids_ff;
  assign defer_id_bus = id_ff;
  assign defer_id_second = sec_ff;
  assign data_return_strobe = ood_ff;
  assign defer_shared_hit = defer_shared_hit_ff;
  assign defer_modified_hit = defer_modified_hit_ff;
  assign retry_reply = retry_ff;
  assign snoop_hold = hold_ff;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_strobe;
    ids_ff;
  endsequence
  sequence s_two_phases;
    ids_ff ##1 (sec_ff && !ids_ff);
  endsequence
  a_strobe_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe |=> !ids_ff)
    else $error("completion strobe on consecutive clocks");
  a_id_two_phase: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe |-> s_two_phases)
    else $error("second id phase missing after strobe");
  a_id_first_value: assert property (@(posedge mclk) disable iff (sys_rst)
    ids_ff && !debug_drive_enable |-> id_ff == cur_ff.txn_id)
    else $error("first id phase differs from captured id");
  a_debug_map: assert property (@(posedge mclk) disable iff (sys_rst)
    sec_ff && debug_drive_enable |-> id_ff[2:0] == cur_ff.coherency_debug_id[2:0]
      && id_ff[7:5] == cur_ff.coherency_debug_id[5:3])
    else $error("debug id not mapped onto second phase");
  a_coincident_data: assert property (@(posedge mclk) disable iff (sys_rst)
    ids_ff && !early_ff && want_data |-> data_return_strobe)
    else $error("data strobe not coincident in default mode");
  a_no_owner_snoop_modified_hit: assert property (@(posedge mclk) disable iff (sys_rst)
    ids_ff && cur_ff.ownership_line_read |-> !defer_modified_hit)
    else $error("modified hit on ownership read completion");
  a_snoop_release: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe |-> !snoop_hold ##1 !snoop_hold)
    else $error("snoop responsibility kept after strobe");
  a_remote_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(ids_ff) && cur_ff.src == bdp_pkg::SRC_REMOTE && !is_retry |-> $past(target_ready_ff))
    else $error("completion before remote target ready");
  a_memory_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(ids_ff) && cur_ff.src == bdp_pkg::SRC_MEMORY && !is_retry |-> $past(hdr_ff))
    else $error("completion before memory read header");
  a_retry_nodata: assert property (@(posedge mclk) disable iff (sys_rst)
    retry_reply |-> !data_return_strobe ##1 !data_return_strobe [*2])
    else $error("data returned with retry completion");
endmodule

// file: testbench/bdp_proc_agent.sv
// ----------------------------------------
// far side: remote bus target ready source
// ----------------------------------------
module bdp_proc_agent (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic snoop_hold,
  input wire logic remote_go,
  input wire logic [3:0] delay,
  output logic remote_target_ready_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_ff = 1'b0;     // last snoop_hold seen
  logic busy_ff = 1'b0;     // a remote write-back is under way
  logic [3:0] cnt_ff = 4'h0; // cycles left before target ready
  // ----------------------------------------
  // ready pulse a chosen delay after the take
  // ----------------------------------------
  // delay 0 answers at once, up to 15 plays a slow remote bus
  always @(posedge mclk)
  begin
    hold_ff <= snoop_hold;
    if (sys_rst)
    begin
      busy_ff <= 1'b0;
      remote_target_ready_pin <= 1'b0;
    end
    else if (snoop_hold && !hold_ff && remote_go)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= delay;
      remote_target_ready_pin <= 1'b0;
    end
    else if (busy_ff && cnt_ff == 4'h0)
    begin
      // one-cycle pulse only: the device has to remember it itself
      remote_target_ready_pin <= 1'b1;
      busy_ff <= 1'b0;
    end
    else
    begin
      remote_target_ready_pin <= 1'b0;
      if (busy_ff)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule

// file: testbench/bdp_defer_phase_tb_top.sv
module bdp_defer_phase_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic mclk, sys_rst, req_valid, req_ready, early_defer_enable, count_drive_enable, debug_drive_enable;
  logic mem_header, data_ready, remote_target_ready_pin, deferral_mark_pin, defer_completion_strobe;
  logic defer_id_second, data_return_strobe, defer_shared_hit, defer_modified_hit, retry_reply, snoop_hold;
  logic remote_go;
  logic [3:0] delay;
  logic [bdp_pkg::ID_W-1:0] defer_id_bus;
  bdp_pkg::bdp_req_s req, r;
  int seed = 32'h1755_bde5; // fixed so runs repeat
  int err_total = 0;
  int n_compared = 0;
  int pend = 0;             // marks sent minus data returned
  bdp_defer_phase dut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .early_defer_enable(early_defer_enable), .count_drive_enable(count_drive_enable),
    .debug_drive_enable(debug_drive_enable), .mem_header(mem_header), .data_ready(data_ready),
    .remote_target_ready_pin(remote_target_ready_pin), .deferral_mark_pin(deferral_mark_pin),
    .defer_completion_strobe(defer_completion_strobe), .defer_id_bus(defer_id_bus),
    .defer_id_second(defer_id_second), .data_return_strobe(data_return_strobe),
    .defer_shared_hit(defer_shared_hit), .defer_modified_hit(defer_modified_hit),
    .retry_reply(retry_reply), .snoop_hold(snoop_hold));
  bdp_proc_agent agent (.mclk(mclk), .sys_rst(sys_rst), .snoop_hold(snoop_hold), .remote_go(remote_go),
    .delay(delay), .remote_target_ready_pin(remote_target_ready_pin));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------------------------------------
  // compare helpers and expectations
  // ----------------------------------------
  task automatic chk1(input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic bdp_pkg::bdp_req_s rnd_req();
    bdp_pkg::bdp_req_s x;
    x = 25'($random(seed));
    x.src = bdp_pkg::bdp_src_e'(2'({$random(seed)} % 3));
    x.has_data = x.src != bdp_pkg::SRC_NONE;
    x.inval_conflict = {$random(seed)} % 8 == 0; // ownership conflicts, also rare
    x.buried_snoop_modified_hit = {$random(seed)} % 6 == 0; // retries kept rare
    return x;
  endfunction
  function automatic logic [7:0] exp_a(bdp_pkg::bdp_req_s x, logic de);
    return de ? {x.coherency_debug_id[6], x.txn_id[6:0]} : x.txn_id;
  endfunction
  // debug mapping wins over the count; snoop results always on bits 4:3
  function automatic logic [7:0] exp_b(bdp_pkg::bdp_req_s x, logic ce, logic de);
    logic [7:0] v;
    v = {3'h0, x.remote_snoop_modified_hit && !x.ownership_line_read, x.shared_hit || x.remote_snooped, 3'h0};
    if (de)
      v = {x.coherency_debug_id[5:3], v[4:3], x.coherency_debug_id[2:0]};
    else if (ce)
      v[7:5] = 3'(pend);
    return v;
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // bus sequences
  // ----------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 60);
    chk1(1'b1, req_ready);
  endtask
  task automatic do_reset(input int n);
    @(posedge mclk);
    sys_rst <= 1'b1;
    req_valid <= 1'b0;
    repeat (n) @(negedge mclk);
    chk1(1'b0, defer_completion_strobe | snoop_hold | req_ready | data_return_strobe | retry_reply);
    chk8(8'h00, defer_id_bus);
    @(posedge mclk);
    sys_rst <= 1'b0;
    pend = 0;
    @(negedge mclk);
    chk1(1'b0, req_ready);
    @(negedge mclk);
    chk1(1'b1, req_ready);
  endtask
  // marks go in while idle so the synchroniser settles before the strobe
  task automatic send_marks(input int m);
    repeat (m)
    begin
      @(posedge mclk);
      deferral_mark_pin <= 1'b1;
      @(posedge mclk);
      deferral_mark_pin <= 1'b0;
      pend++;
    end
    repeat (4) @(posedge mclk);
  endtask
  // md: bit0 early mode, bit1 count enable, bit2 debug enable
  task automatic run_txn(input bdp_pkg::bdp_req_s x, input logic [2:0] md, input int hd, input int dly);
    int k;
    int rk;
    int sk;
    logic rty;
    logic mem;
    rty = x.buried_snoop_modified_hit | x.inval_conflict;
    mem = x.src == bdp_pkg::SRC_MEMORY;
    k = 0;
    rk = 99;
    sk = 0;
    wait_ready();
    @(posedge mclk);
    req <= x;
    req_valid <= 1'b1;
    early_defer_enable <= md[0];
    count_drive_enable <= md[1];
    debug_drive_enable <= md[2];
    data_ready <= !md[0];
    remote_go <= x.src == bdp_pkg::SRC_REMOTE && !rty;
    delay <= 4'(dly);
    while (sk == 0 && k < 80)
    begin
      @(posedge mclk);
      k++;
      req_valid <= 1'b0;
      mem_header <= mem && k == hd;
      @(negedge mclk);
      if (remote_target_ready_pin === 1'b1)
        rk = k;
      if (k == 1)
        chk1(1'b1, snoop_hold);
      if (defer_completion_strobe === 1'b1)
        sk = k;
    end
    if (rty || x.src == bdp_pkg::SRC_NONE)
      chkn(2, sk);
    else if (mem)
      chkn(hd + 2, sk);
    else
      chkn(rk + 4, sk);
    chk8(exp_a(x, md[2]), defer_id_bus);
    chk1(1'b0, snoop_hold);
    chk1(rty, retry_reply);
    chk1(!md[0] && x.has_data && !rty, data_return_strobe);
    if (!rty)
      chk1(x.remote_snoop_modified_hit && !x.ownership_line_read, defer_modified_hit);
    if (!rty)
      chk1(x.data_line_read && (x.shared_hit || x.remote_snooped), defer_shared_hit);
    @(negedge mclk);
    chk1(1'b1, defer_id_second);
    chk8(exp_b(x, md[1], md[2]), defer_id_bus);
    chk1(1'b0, data_return_strobe);
    if (md[0] && x.has_data && !rty)
    begin
      @(posedge mclk);
      data_ready <= 1'b1;
      @(negedge mclk);
      chk1(1'b0, data_return_strobe);
      @(negedge mclk);
      chk1(1'b1, data_return_strobe);
    end
    if (x.has_data && !rty)
      pend--;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    {early_defer_enable, count_drive_enable, debug_drive_enable, mem_header, deferral_mark_pin} = 5'h00;
    data_ready = 1'b1;
    remote_go = 1'b0;
    delay = 4'h0;
    do_reset(12);
    $display("test reset done");
    r = rnd_req();
    r.src = bdp_pkg::SRC_MEMORY;
    r.has_data = 1'b1;
    r.buried_snoop_modified_hit = 1'b1;
    run_txn(r, 3'h6, 5, 0);
    send_marks(9);
    repeat (150)
    begin
      send_marks({$random(seed)} % 3);
      run_txn(rnd_req(), 3'($random(seed)), 1 + {$random(seed)} % 8, {$random(seed)} % 16);
    end
    $display("test random done");
    wait_ready();
    @(posedge mclk);
    r.buried_snoop_modified_hit = 1'b0;
    req <= r;
    req_valid <= 1'b1;
    do_reset(2);
    repeat (5) run_txn(rnd_req(), 3'($random(seed)), 2, 3);
    $display("test mid reset done");
    stop_test();
  end
  // about 100 us of traffic expected, so 2 ms means a hang
  initial
  begin
    #(2_000_000);
    err_total++;
    stop_test();
  end
endmodule
